// file: inc/spu_pkg.sv
// Constants, register map and carrier types for the clocked serial port.
package spu_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] SPU_OFS_CTRL  = 8'h00;
  localparam logic [7:0] SPU_OFS_STAT  = 8'h04;
  localparam logic [7:0] SPU_OFS_TXBUF = 8'h08;
  localparam logic [7:0] SPU_OFS_RXBUF = 8'h0C;
  localparam logic [7:0] SPU_OFS_DIV   = 8'h10;
  localparam logic [7:0] SPU_OFS_IRQ   = 8'h14;

  // Reset values.
  localparam logic [7:0] SPU_CTRL_RST = 8'h00;
  localparam logic [7:0] SPU_STAT_RST = 8'h80;
  localparam logic [7:0] SPU_DIV_RST  = 8'h03;

  // Serial framing figures.
  localparam logic [2:0] SPU_LAST_BIT  = 3'h7;
  localparam logic [3:0] SPU_MID_SUB   = 4'h7;
  localparam logic [3:0] SPU_STOP_NP   = 4'h9;
  localparam logic [3:0] SPU_STOP_PAR  = 4'hA;
  localparam logic [3:0] SPU_PAR_IDX   = 4'h9;
  localparam logic [3:0] SPU_DATA_LO   = 4'h1;
  localparam logic [3:0] SPU_DATA_HI   = 4'h8;

  // Interrupt source codes, highest priority first.
  localparam logic [2:0] SPU_IRQ_FAULT = 3'h4;
  localparam logic [2:0] SPU_IRQ_FULL  = 3'h3;
  localparam logic [2:0] SPU_IRQ_EMPTY = 3'h2;
  localparam logic [2:0] SPU_IRQ_DONE  = 3'h1;
  localparam logic [2:0] SPU_IRQ_NONE  = 3'h0;

  // Control byte layout.
  typedef struct packed {
    logic async_mode;
    logic par_en;
    logic rx_irq_en;
    logic tx_done_irq_en;
    logic tx_empty_irq_en;
    logic clk_ext;
    logic rx_enable;
    logic tx_enable;
  } spu_ctrl_t;

  // Status byte layout; the two low bits read as zero.
  typedef struct packed {
    logic       tx_buf_empty_flag;
    logic       rx_full_flag;
    logic       overrun_flag;
    logic       framing_flag;
    logic       parity_flag;
    logic       tx_done_flag;
    logic [1:0] zero;
  } spu_stat_t;

  // Transmit sequencer states, Gray coded.
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01,
    TX_TAIL  = 2'b11
  } spu_tx_state_t;

endpackage : spu_pkg

// file: src/spu_sync.sv
// Clocked synchronous serial port with asynchronous receive, APB registers and four interrupt lines.
// Behaviour
// - No start while any receive error flag set.
// - Empty flag clear means buffer holds new byte.
// - Load sets empty flag, starts shifting, interrupt.
// - Internal clock: eight pulses; external: follow clock.
// - Transmit bits least significant first.
// - At bit seven, chain next byte without gap.
// - Nothing pending at bit seven: done flag, hold.
// - Serial clock rests high after transmission.
// - Error flags block full flag and transfers.
// - Receive clock starts when receive enabled.
// - Clock stops on overrun, resumes when cleared.
// - Receive LSB first; copy when buffer empty.
// - Full and overrun interrupts gated by enable.
// - Simultaneous mode: clock starts with transmission.
// - Four lines, fault OR of errors, prioritised.
// - Buffer writes always accepted, may overwrite.
// - Error flags independent; overrun blocks copy.
// - Line break gives framing error, zero byte.
// - Asynchronous receive samples sixteen times per bit.
// - Transmit on falling edge, sample on rising.
// - Synchronous character: eight bits, no parity.
// - Idle internal clock output held high.
//
// The APB register port and the address map are this design's own decisions.
module spu_sync
  import spu_pkg::*;
#(
  parameter logic [7:0] DIV_DEFAULT = SPU_DIV_RST
) (
  input  wire logic        clk,          // System clock, 20 MHz.
  input  wire logic        rst_n,        // Asynchronous reset, active low.
  input  wire logic        psel,         // APB select.
  input  wire logic        penable,      // APB access phase.
  input  wire logic        pwrite,       // APB write direction.
  input  wire logic [7:0]  paddr,        // APB byte address.
  input  wire logic [31:0] pwdata,       // APB write data.
  output logic      [31:0] prdata,       // APB read data.
  output logic             pready,       // APB ready.
  output logic             pslverr,      // APB error for unmapped address.
  input  wire logic        rxd_i,        // Serial receive data pin.
  output logic             txd_o,        // Serial transmit data pin.
  input  wire logic        sck_i,        // Serial clock pin, input side.
  output logic             sck_o,        // Serial clock pin, output side.
  output logic             sck_oe_n,     // Serial clock drive enable, low drives.
  output logic             rx_fault_irq, // Receive error interrupt.
  output logic             rx_full_irq,  // Receive buffer full interrupt.
  output logic             tx_empty_irq, // Transmit buffer empty interrupt.
  output logic             tx_done_irq   // Transmission ended interrupt.
);

  spu_ctrl_t     ctrl_reg;
  spu_stat_t     stat_reg;
  spu_tx_state_t tx_st_reg;
  logic [7:0]    tx_buffer_reg;
  logic [7:0]    rx_buffer_reg;
  logic [7:0]    div_reg;
  logic [7:0]    div_cnt_reg;
  logic          sck_reg;
  logic [7:0]    tx_shifter_reg;
  logic [2:0]    tx_cnt_reg;
  logic [7:0]    rx_shifter_reg;
  logic [2:0]    rx_cnt_reg;
  logic          rxd_s1_reg, rxd_s2_reg;
  logic          sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic          a_busy_reg;
  logic [3:0]    a_sub_reg;
  logic [3:0]    a_bit_reg;
  logic [7:0]    a_shifter_reg;
  logic          a_par_reg;
  logic [2:0]    irq_src_reg;

  logic        access, wr_fire, err, clk_run_int, div_run, tick;
  logic        int_fall, int_rise, fall_ev, rise_ev;
  logic        tx_start, tx_chain, tx_end, rx_done_sync;
  logic        a_done, a_fer, a_per, rx_done;
  logic [7:0]  rx_byte;
  logic [3:0]  a_stop_idx;
  logic [31:0] rd_word;
  logic        rd_ok;

  // Two-flop synchronisers for the pins; the third clock stage feeds edge detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      sck_s1_reg <= 1'b1;
      sck_s2_reg <= 1'b1;
      sck_s3_reg <= 1'b1;
    end else begin
      rxd_s1_reg <= rxd_i;
      rxd_s2_reg <= rxd_s1_reg;
      sck_s1_reg <= sck_i;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
    end
  end

  // Any receive error freezes the whole port.
  assign err = stat_reg.overrun_flag | stat_reg.framing_flag | stat_reg.parity_flag;

  // Clock generation and serial edge events.
  // clock follows transmission
  // When both directions are enabled the clock only runs with a transmission.
  assign clk_run_int = !ctrl_reg.async_mode && !ctrl_reg.clk_ext && !err &&
                       ((tx_st_reg != TX_IDLE) || (ctrl_reg.rx_enable && !ctrl_reg.tx_enable));
  assign div_run  = clk_run_int | ctrl_reg.async_mode;
  assign tick     = div_run && (div_cnt_reg == div_reg);
  assign int_fall = clk_run_int && tick && sck_reg;
  assign int_rise = clk_run_int && tick && !sck_reg;
  assign fall_ev  = ctrl_reg.clk_ext ? (!sck_s2_reg && sck_s3_reg) : int_fall;
  assign rise_ev  = ctrl_reg.clk_ext ? (sck_s2_reg && !sck_s3_reg) : int_rise;

  // Divider: half serial clock period, or one sixteenth of a bit in asynchronous mode.
  // clock rests high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 8'h00;
      sck_reg     <= 1'b1;
    end else if (!div_run) begin
      div_cnt_reg <= 8'h00;
      sck_reg     <= 1'b1;
    end else if (tick) begin
      div_cnt_reg <= 8'h00;
      if (clk_run_int) begin
        sck_reg <= ~sck_reg;
      end
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // Transmit decisions.
  // no start on error
  assign tx_start = ctrl_reg.tx_enable && !ctrl_reg.async_mode && !err &&
                    !stat_reg.tx_buf_empty_flag && (tx_st_reg == TX_IDLE);
  assign tx_chain = (tx_st_reg == TX_SHIFT) && !err && fall_ev && (tx_cnt_reg == SPU_LAST_BIT) &&
                    ctrl_reg.tx_enable && !stat_reg.tx_buf_empty_flag;
  assign tx_end   = (tx_st_reg == TX_SHIFT) && !err && fall_ev && (tx_cnt_reg == SPU_LAST_BIT) &&
                    !tx_chain;

  // Transmit sequencer: a bit leaves on each falling edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_reg      <= TX_IDLE;
      tx_shifter_reg <= 8'h00;
      tx_cnt_reg     <= 3'h0;
      txd_o          <= 1'b1;
    end else begin
      case (tx_st_reg)
        TX_IDLE: begin
          if (tx_start) begin
            tx_shifter_reg <= tx_buffer_reg;
            tx_cnt_reg     <= 3'h0;
            tx_st_reg      <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (err || !ctrl_reg.tx_enable) begin
            tx_st_reg <= TX_IDLE;
          end else if (fall_ev) begin
            txd_o <= tx_shifter_reg[tx_cnt_reg];
            if (tx_chain) begin
              tx_shifter_reg <= tx_buffer_reg;
              tx_cnt_reg     <= 3'h0;
            end else if (tx_end) begin
              tx_st_reg <= TX_TAIL;
            end else begin
              tx_cnt_reg <= tx_cnt_reg + 3'h1;
            end
          end
        end
        TX_TAIL: begin
          // Bit seven stays on the line; the last rising edge ends the frame.
          if (rise_ev || err) begin
            tx_st_reg <= TX_IDLE;
          end
        end
        default: begin
          tx_st_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // Synchronous receiver: a bit enters on each rising edge.
  // sample when enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shifter_reg <= 8'h00;
      rx_cnt_reg     <= 3'h0;
    end else if (!ctrl_reg.rx_enable || err || ctrl_reg.async_mode) begin
      rx_cnt_reg <= 3'h0;
    end else if (rise_ev) begin
      rx_shifter_reg <= {rxd_s2_reg, rx_shifter_reg[7:1]};
      rx_cnt_reg     <= rx_cnt_reg + 3'h1;
    end
  end
  assign rx_done_sync = ctrl_reg.rx_enable && !err && !ctrl_reg.async_mode && rise_ev &&
                        (rx_cnt_reg == SPU_LAST_BIT);

  // Asynchronous receiver on the sixteen-times tick.
  // sixteen samples per bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_busy_reg    <= 1'b0;
      a_sub_reg     <= 4'h0;
      a_bit_reg     <= 4'h0;
      a_shifter_reg <= 8'h00;
      a_par_reg     <= 1'b0;
    end else if (!ctrl_reg.async_mode || !ctrl_reg.rx_enable) begin
      a_busy_reg <= 1'b0;
    end else if (tick) begin
      if (!a_busy_reg) begin
        if (!rxd_s2_reg && !err) begin
          a_busy_reg <= 1'b1;
          a_sub_reg  <= 4'h0;
          a_bit_reg  <= 4'h0;
        end
      end else begin
        a_sub_reg <= a_sub_reg + 4'h1;
        if (a_sub_reg == SPU_MID_SUB) begin
          a_bit_reg <= a_bit_reg + 4'h1;
          if (a_bit_reg == 4'h0 && rxd_s2_reg) begin
            a_busy_reg <= 1'b0;
          end else if (a_bit_reg >= SPU_DATA_LO && a_bit_reg <= SPU_DATA_HI) begin
            a_shifter_reg <= {rxd_s2_reg, a_shifter_reg[7:1]};
          end else if (a_bit_reg == a_stop_idx) begin
            a_busy_reg <= 1'b0;
          end else begin
            a_par_reg <= rxd_s2_reg;
          end
        end
      end
    end
  end
  assign a_stop_idx = ctrl_reg.par_en ? SPU_STOP_PAR : SPU_STOP_NP;
  assign a_done = ctrl_reg.async_mode && ctrl_reg.rx_enable && tick && a_busy_reg &&
                  (a_sub_reg == SPU_MID_SUB) && (a_bit_reg == a_stop_idx);
  // low stop bit is a framing error
  assign a_fer  = !rxd_s2_reg;
  assign a_per  = ctrl_reg.par_en && ((^a_shifter_reg) ^ a_par_reg);
  assign rx_done = rx_done_sync | a_done;
  assign rx_byte = ctrl_reg.async_mode ? a_shifter_reg : {rxd_s2_reg, rx_shifter_reg[7:1]};

  // APB handshake: one wait state, then the transfer completes.
  assign access  = psel && penable;
  assign wr_fire = access && pready && pwrite;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      if (access && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= !rd_ok;
      end
    end
  end

  // Read multiplexer and address decode.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (paddr == SPU_OFS_CTRL) begin
      rd_word = {24'h000000, ctrl_reg};
    end else if (paddr == SPU_OFS_STAT) begin
      rd_word = {24'h000000, stat_reg};
    end else if (paddr == SPU_OFS_TXBUF) begin
      rd_word = {24'h000000, tx_buffer_reg};
    end else if (paddr == SPU_OFS_RXBUF) begin
      rd_word = {24'h000000, rx_buffer_reg};
    end else if (paddr == SPU_OFS_DIV) begin
      rd_word = {24'h000000, div_reg};
    end else if (paddr == SPU_OFS_IRQ) begin
      rd_word = {29'h0000000, irq_src_reg};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Software-written configuration and transmit buffer.
  // writes always accepted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg      <= SPU_CTRL_RST;
      div_reg       <= DIV_DEFAULT;
      tx_buffer_reg <= 8'h00;
    end else if (wr_fire) begin
      if (paddr == SPU_OFS_CTRL) begin
        ctrl_reg <= pwdata[7:0];
      end else if (paddr == SPU_OFS_DIV) begin
        div_reg <= pwdata[7:0];
      end else if (paddr == SPU_OFS_TXBUF) begin
        tx_buffer_reg <= pwdata[7:0];
      end
    end
  end

  // Status flags: hardware sets win over a software write of zero in the same cycle.
  logic wr_stat;
  assign wr_stat = wr_fire && (paddr == SPU_OFS_STAT);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg      <= SPU_STAT_RST;
      rx_buffer_reg <= 8'h00;
    end else begin
      stat_reg.tx_buf_empty_flag <= (tx_start || tx_chain) ||
                                    (stat_reg.tx_buf_empty_flag && !(wr_stat && !pwdata[7]));
      stat_reg.tx_done_flag <= tx_end ||
                               (stat_reg.tx_done_flag && !tx_start && !(wr_stat && !pwdata[2]));
      stat_reg.overrun_flag <= (rx_done && stat_reg.rx_full_flag) ||
                               (stat_reg.overrun_flag && !(wr_stat && !pwdata[5]));
      stat_reg.framing_flag <= (a_done && a_fer) ||
                               (stat_reg.framing_flag && !(wr_stat && !pwdata[4]));
      stat_reg.parity_flag  <= (a_done && a_per) ||
                               (stat_reg.parity_flag && !(wr_stat && !pwdata[3]));
      stat_reg.rx_full_flag <= (rx_done && !stat_reg.rx_full_flag && !(a_done && (a_fer || a_per))) ||
                               (stat_reg.rx_full_flag && !(wr_stat && !pwdata[6]));
      stat_reg.zero <= 2'b00;
      // line break copies a zero byte
      if (rx_done && !stat_reg.rx_full_flag) begin
        rx_buffer_reg <= rx_byte;
      end
    end
  end

  // Interrupt lines and prioritised source code, all registered.
  // gate by receive interrupt enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_fault_irq <= 1'b0;
      rx_full_irq  <= 1'b0;
      tx_empty_irq <= 1'b0;
      tx_done_irq  <= 1'b0;
      irq_src_reg  <= SPU_IRQ_NONE;
    end else begin
      rx_fault_irq <= ctrl_reg.rx_irq_en && err;
      rx_full_irq  <= ctrl_reg.rx_irq_en && stat_reg.rx_full_flag;
      tx_empty_irq <= ctrl_reg.tx_empty_irq_en && stat_reg.tx_buf_empty_flag;
      tx_done_irq  <= ctrl_reg.tx_done_irq_en && stat_reg.tx_done_flag;
      if (ctrl_reg.rx_irq_en && err) begin
        irq_src_reg <= SPU_IRQ_FAULT;
      end else if (ctrl_reg.rx_irq_en && stat_reg.rx_full_flag) begin
        irq_src_reg <= SPU_IRQ_FULL;
      end else if (ctrl_reg.tx_empty_irq_en && stat_reg.tx_buf_empty_flag) begin
        irq_src_reg <= SPU_IRQ_EMPTY;
      end else if (ctrl_reg.tx_done_irq_en && stat_reg.tx_done_flag) begin
        irq_src_reg <= SPU_IRQ_DONE;
      end else begin
        irq_src_reg <= SPU_IRQ_NONE;
      end
    end
  end

  // Serial clock pin: driven only with the internal clock in synchronous mode.
  // idle clock high
  // The pin shows the divider flop itself, so data and clock change on one edge.
  assign sck_o = sck_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_oe_n <= 1'b1;
    end else begin
      sck_oe_n <= ctrl_reg.clk_ext || ctrl_reg.async_mode;
    end
  end

endmodule : spu_sync

// file: test/spu_peer.sv
// Serial peer model: samples transmit data, supplies receive data, makes an external clock.
module spu_peer (
  input  wire logic sck,    // Clock pin level.
  input  wire logic txd,    // Device transmit data.
  output logic      rxd,    // Device receive data.
  output logic      sck_ext // Peer clock, high outside frames.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cap;
  logic [7:0]  rx_byte;
  int          nrise;
  int          nfall;

  // Idle levels at time zero.
  initial begin
    cap = 16'h0000;
    rx_byte = 8'h00;
    nrise = 0;
    nfall = 0;
    rxd = 1'b1;
    sck_ext = 1'b1;
  end
  always @(posedge sck) begin
    cap   <= {txd, cap[15:1]};
    nrise <= nrise + 1;
  end
  always @(negedge sck) begin
    rxd   <= rx_byte[nfall[2:0]];
    nfall <= nfall + 1;
  end
  // Eight cycles of 400 ns, then the data line flips so stale bits never pass.
  task automatic ext_frame();
    #37;
    repeat (8) begin
      sck_ext = 1'b0;
      #200;
      sck_ext = 1'b1;
      #200;
    end
    rxd = ~rxd;
  endtask : ext_frame
endmodule : spu_peer

// file: test/spu_sync_props.sv
// Checker of serial clock, data and bus timing at the port boundary.
module spu_sync_props
  import spu_pkg::*;
#(
  parameter logic [7:0] DIV_DEFAULT = SPU_DIV_RST
) (
  input wire logic        clk,          // Clock.
  input wire logic        rst_n,        // Reset, active low.
  input wire logic        psel,         // Select.
  input wire logic        penable,      // Access phase.
  input wire logic        pwrite,       // Direction.
  input wire logic [7:0]  paddr,        // Address.
  input wire logic [31:0] pwdata,       // Write data.
  input wire logic [31:0] prdata,       // Read data.
  input wire logic        pready,       // Ready.
  input wire logic        pslverr,      // Error.
  input wire logic        rxd_i,        // Receive pin.
  input wire logic        txd_o,        // Transmit pin.
  input wire logic        sck_i,        // Clock pin in.
  input wire logic        sck_o,        // Clock pin out.
  input wire logic        sck_oe_n,     // Clock drive, low drives.
  input wire logic        rx_fault_irq, // Fault line.
  input wire logic        rx_full_irq,  // Full line.
  input wire logic        tx_empty_irq, // Empty line.
  input wire logic        tx_done_irq   // Done line.
);
  // The half-period widths below hold for the reset divider value 03.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // The slave inserts exactly one wait state.
  property p_apb_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("bus wait state wrong");
  property p_sck_low;
    $fell(sck_o) && !sck_oe_n |-> !sck_o [*4] ##1 sck_o;
  endproperty
  a_sck_low: assert property (p_sck_low) else $error("clock low width wrong");
  property p_sck_high;
    $rose(sck_o) && !sck_oe_n |-> sck_o [*4];
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("clock high width wrong");
  property p_txd_stable;
    !sck_oe_n && sck_o && $past(sck_o) |-> $stable(txd_o);
  endproperty
  a_txd_stable: assert property (p_txd_stable) else $error("data moved while clock high");
  property p_done_last;
    $rose(tx_done_irq) && !sck_oe_n |-> !sck_o ##[1:8] sck_o;
  endproperty
  a_done_last: assert property (p_done_last) else $error("done not in last bit");
  property p_done_rest;
    tx_done_irq && sck_o |=> sck_o || !tx_done_irq;
  endproperty
  a_done_rest: assert property (p_done_rest) else $error("clock moved after end");
  property p_fault_stop;
    $rose(rx_fault_irq) && !sck_oe_n |-> sck_o [*8];
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("clock ran on overrun");
  property p_full_edge;
    $rose(rx_full_irq) && !sck_oe_n |-> sck_o;
  endproperty
  a_full_edge: assert property (p_full_edge) else $error("full raised with clock low");
  property p_idle_high;
    $changed(sck_oe_n) |-> sck_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("clock low at mode change");

  // Main scenarios reached.
  c_fault: cover property ($rose(rx_fault_irq));
  c_done: cover property ($rose(tx_done_irq));
  c_ext: cover property (sck_oe_n && $fell(sck_i));
endmodule : spu_sync_props

// file: test/spu_sync_tb_top.sv
// Self-checking bench for the clocked serial port.
module spu_sync_tb_top
  import spu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] DIV_DEFAULT = SPU_DIV_RST;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, rxd_i, txd_o, sck_o, sck_oe_n, sck_ext, e;
  logic        rx_fault_irq, rx_full_irq, tx_empty_irq, tx_done_irq;
  logic [7:0]  paddr, b0, b1, rb;
  logic [31:0] pwdata, prdata, q;
  wire  logic  sck_pin;
  wire  logic [3:0] irqs;
  int          errors, num_checks;
  integer      seed;

  // Pin level from both drivers, and the four lines gathered.
  assign sck_pin = sck_oe_n ? sck_ext : sck_o;
  assign irqs = {rx_fault_irq, rx_full_irq, tx_empty_irq, tx_done_irq};

  spu_sync #(.DIV_DEFAULT(DIV_DEFAULT)) spu_sync_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_i(rxd_i), .txd_o(txd_o), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
    .rx_fault_irq(rx_fault_irq), .rx_full_irq(rx_full_irq), .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq));
  spu_peer spu_peer_inst (.sck(sck_pin), .txd(txd_o), .rxd(rxd_i), .sck_ext(sck_ext));

  // Clock of 50 ns.
  always #25 clk = ~clk;

  function automatic logic [31:0] stat_exp(input logic [5:0] f);
    return {24'h0, f, 2'b00};
  endfunction : stat_exp
  function automatic logic [31:0] irq_src(input logic f, input logic r, input logic m, input logic d);
    return {29'h0, f ? SPU_IRQ_FAULT : r ? SPU_IRQ_FULL : m ? SPU_IRQ_EMPTY : d ? SPU_IRQ_DONE : SPU_IRQ_NONE};
  endfunction : irq_src
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One transfer: setup, access, hold until ready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask : rd
  task automatic wait_irq(input int k, input int lim);
    int n;
    n = 0;
    while (irqs[k] !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, irqs[k]}, 32'h1);
  endtask : wait_irq
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Watchdog against a run that never ends.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[ERR] %0t run did not end", $time);
    summarize();
  end

  // Main sequence.
  initial begin
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    errors = 0; num_checks = 0; seed = 32'hA272A183;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(SPU_OFS_CTRL, {24'h0, SPU_CTRL_RST});
    rd(SPU_OFS_STAT, {24'h0, SPU_STAT_RST});
    rd(SPU_OFS_DIV, {24'h0, SPU_DIV_RST});
    apb(1'b0, 8'h18, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    // Two chained bytes on the internal clock.
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    wr(SPU_OFS_CTRL, 8'h19);
    wr(SPU_OFS_TXBUF, ~b0);
    wr(SPU_OFS_TXBUF, b0);
    spu_peer_inst.nrise = 0;
    wr(SPU_OFS_STAT, 8'h7F);
    repeat (2) @(posedge clk);
    wait_irq(1, 20);
    wr(SPU_OFS_TXBUF, b1);
    wr(SPU_OFS_STAT, 8'h7F);
    wait_irq(0, 400);
    repeat (10) @(posedge clk);
    check({16'h0, spu_peer_inst.cap}, {16'h0, b1, b0});
    check(spu_peer_inst.nrise, 16);
    check({31'h0, sck_o}, 32'h1);
    check({31'h0, txd_o}, {31'h0, b1[7]});
    rd(SPU_OFS_STAT, stat_exp(6'b100001));
    // Receive only until a dummy byte overruns.
    wr(SPU_OFS_CTRL, 8'h00);
    rb = 8'($random(seed));
    spu_peer_inst.rx_byte = rb;
    spu_peer_inst.nfall = 0;
    spu_peer_inst.nrise = 0;
    wr(SPU_OFS_CTRL, 8'h22);
    wait_irq(2, 300);
    wait_irq(3, 300);
    repeat (40) @(posedge clk);
    check(spu_peer_inst.nrise, 16);
    rd(SPU_OFS_RXBUF, {24'h0, rb});
    rd(SPU_OFS_STAT, stat_exp(6'b111001));
    rd(SPU_OFS_IRQ, irq_src(1'b1, 1'b1, 1'b0, 1'b0));
    // No start while the overrun stands.
    wr(SPU_OFS_CTRL, 8'h00);
    wr(SPU_OFS_CTRL, 8'h23);
    b0 = 8'($random(seed));
    wr(SPU_OFS_TXBUF, b0);
    wr(SPU_OFS_STAT, 8'h7F);
    repeat (40) @(posedge clk);
    rd(SPU_OFS_STAT, stat_exp(6'b011001));
    check(spu_peer_inst.nrise, 16);
    // Clearing the flags starts both directions together.
    rb = 8'($random(seed));
    spu_peer_inst.rx_byte = rb;
    spu_peer_inst.nfall = 0;
    spu_peer_inst.nrise = 0;
    wr(SPU_OFS_STAT, 8'h9F);
    repeat (2) @(posedge clk);
    wait_irq(2, 300);
    repeat (10) @(posedge clk);
    check({24'h0, spu_peer_inst.cap[15:8]}, {24'h0, b0});
    check(spu_peer_inst.nrise, 8);
    rd(SPU_OFS_RXBUF, {24'h0, rb});
    // External clock frames, corner bytes first.
    wr(SPU_OFS_CTRL, 8'h00);
    wr(SPU_OFS_CTRL, 8'h07);
    repeat (2) @(posedge clk);
    check({31'h0, sck_oe_n}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      b0 = (i == 0) ? 8'h00 : 8'($random(seed));
      rb = (i == 0) ? 8'hFF : 8'($random(seed));
      spu_peer_inst.rx_byte = rb;
      spu_peer_inst.nfall = 0;
      wr(SPU_OFS_TXBUF, b0);
      wr(SPU_OFS_STAT, 8'h3F);
      spu_peer_inst.ext_frame();
      repeat (10) @(posedge clk);
      check({24'h0, spu_peer_inst.cap[15:8]}, {24'h0, b0});
      rd(SPU_OFS_RXBUF, {24'h0, rb});
    end
    // A held-low line in asynchronous receive gives a framing error and a zero byte.
    spu_peer_inst.rxd = 1'b0;
    wr(SPU_OFS_CTRL, 8'hA2);
    wr(SPU_OFS_STAT, 8'hBF);
    wait_irq(3, 1000);
    rd(SPU_OFS_RXBUF, 32'h0);
    rd(SPU_OFS_STAT, stat_exp(6'b100101));
    summarize();
  end
endmodule : spu_sync_tb_top

bind spu_sync spu_sync_props #(.DIV_DEFAULT(DIV_DEFAULT)) spu_sync_props_inst (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd_i(rxd_i), .txd_o(txd_o), .sck_i(sck_i), .sck_o(sck_o),
  .sck_oe_n(sck_oe_n), .rx_fault_irq(rx_fault_irq), .rx_full_irq(rx_full_irq), .tx_empty_irq(tx_empty_irq),
  .tx_done_irq(tx_done_irq));
